// ### src/abd_pkg.sv
// Package with constants, types and register map of the add and bit ops datapath.
package abd_pkg;

  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FILE_AW     = 7;
  localparam int unsigned FILE_DEPTH  = 128;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CMD    = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_ACC    = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h008;
  localparam int unsigned       FILE_SEL_BIT = 9;
  localparam int unsigned       FILE_IDX_LSB = 2;

  // Index of the file register that is the I/O port.
  localparam logic [FILE_AW-1:0] IO_PORT_INDEX = 7'h06;

  // Command register fields.
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_DEST_BIT = 4;
  localparam int unsigned CMD_BIT_LSB  = 5;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_LIT_LSB  = 16;

  // Status register fields.
  localparam int unsigned ST_CARRY     = 0;
  localparam int unsigned ST_HALF      = 1;
  localparam int unsigned ST_ZERO      = 2;
  localparam int unsigned ST_SKIP      = 3;
  localparam int unsigned ST_BUSY      = 4;

  localparam logic [BYTE_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] FILE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_IDLE_CYCLE         = 4'h0,
    OP_ADD_IMMEDIATE      = 4'h1,
    OP_ADD_ACC_WITH_FILE  = 4'h2,
    OP_AND_IMMEDIATE      = 4'h3,
    OP_AND_ACC_WITH_FILE  = 4'h4,
    OP_FILE_BIT_CLEAR     = 4'h5,
    OP_FILE_BIT_SET       = 4'h6,
    OP_SKIP_WHEN_BIT_LOW  = 4'h7,
    OP_SKIP_WHEN_BIT_HIGH = 4'h8
  } abd_op_t;

  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_EXEC  = 2'b01
  } abd_state_t;

  typedef struct packed {
    abd_op_t              op;
    logic                 dest_file;
    logic [2:0]           bit_sel;
    logic [FILE_AW-1:0]   file_addr;
    logic [BYTE_W-1:0]    literal;
  } abd_cmd_t;

  typedef struct packed {
    logic                 carry;
    logic                 half_carry_flag;
    logic                 zero;
  } abd_flags_t;

endpackage

// ### src/abd_datapath.sv
// Add, AND and single-bit execution datapath with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module abd_datapath (
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  input  wire logic [abd_pkg::ADDR_W-1:0]    avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [abd_pkg::DATA_W-1:0]    avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [abd_pkg::DATA_W-1:0]    avs_readdata_out,
  output logic                               avs_waitrequest_out,
  input  wire logic [abd_pkg::BYTE_W-1:0]    port_pins_in,
  output logic      [abd_pkg::BYTE_W-1:0]    port_latch_out,
  output logic                               skip_out,
  output logic                               busy_out
);
  import abd_pkg::*;

  // ----------------------------------------------------------------------
  // State record.
  // ----------------------------------------------------------------------
  typedef struct packed {
    abd_state_t                           state;
    abd_cmd_t                             cmd;
    logic [BYTE_W-1:0]                    acc;
    abd_flags_t                           flags;
    logic                                 skip_pending;
    logic                                 skip;
    logic                                 busy;
    logic [FILE_DEPTH-1:0][BYTE_W-1:0]    files;
    logic [BYTE_W-1:0]                    pin_s1;
    logic [BYTE_W-1:0]                    pin_s2;
    logic [BYTE_W-1:0]                    pin_s3;
    logic [BYTE_W-1:0]                    pins;
    logic                                 waitreq;
    logic [DATA_W-1:0]                    rdata;
  } abd_regs_t;

  abd_regs_t r;
  abd_regs_t next_r;

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0]        be);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  logic                  req;
  logic                  ack_edge;
  logic                  file_hit;
  logic [FILE_AW-1:0]    bus_idx;
  logic [DATA_W-1:0]     cmd_word;
  logic [DATA_W-1:0]     status_word;
  logic [DATA_W-1:0]     cmd_merged;
  logic [DATA_W-1:0]     acc_merged;
  logic [DATA_W-1:0]     st_merged;
  logic [DATA_W-1:0]     file_merged;
  logic [BYTE_W-1:0]     src_file;
  logic [BYTE_W-1:0]     result;
  logic [BYTE_W:0]       sum9;
  logic [4:0]            sum_low;
  logic [BYTE_W-1:0]     add_b;
  logic                  tested_bit;

  assign req      = avs_read_in | avs_write_in;
  assign file_hit = avs_address_in[FILE_SEL_BIT];
  assign bus_idx  = avs_address_in[FILE_IDX_LSB +: FILE_AW];
  // A request is taken on the edge where waitrequest is already low.
  assign ack_edge = req & ~r.waitreq;

  assign cmd_merged  = merge_lanes(cmd_word, avs_writedata_in, avs_byteenable_in);
  assign acc_merged  = merge_lanes(DATA_W'(r.acc), avs_writedata_in, avs_byteenable_in);
  assign st_merged   = merge_lanes(status_word, avs_writedata_in, avs_byteenable_in);
  assign file_merged = merge_lanes(DATA_W'(r.files[bus_idx]), avs_writedata_in,
                                   avs_byteenable_in);

  // ----------------------------------------------------------------------
  // Register word packing.
  // ----------------------------------------------------------------------
  // Fields sit at the package offsets, so reads and writes share one layout.
  always_comb begin
    cmd_word                                      = '0;
    cmd_word[CMD_OP_LSB +: $bits(abd_op_t)]       = r.cmd.op;
    cmd_word[CMD_DEST_BIT]                        = r.cmd.dest_file;
    cmd_word[CMD_BIT_LSB +: 3]                    = r.cmd.bit_sel;
    cmd_word[CMD_ADDR_LSB +: FILE_AW]             = r.cmd.file_addr;
    cmd_word[CMD_LIT_LSB +: BYTE_W]               = r.cmd.literal;
    status_word                                   = '0;
    status_word[ST_CARRY]                         = r.flags.carry;
    status_word[ST_HALF]                          = r.flags.half_carry_flag;
    status_word[ST_ZERO]                          = r.flags.zero;
    status_word[ST_SKIP]                          = r.skip_pending;
  end

  // ----------------------------------------------------------------------
  // Operand selection and arithmetic.
  // ----------------------------------------------------------------------
  always_comb begin
    // The port index reads the pins, so a read-modify-write keeps what outside drives.
    if (r.cmd.file_addr == IO_PORT_INDEX) begin
      src_file = r.pins;
    end else begin
      src_file = r.files[r.cmd.file_addr];
    end
    if (r.cmd.op == OP_ADD_IMMEDIATE) begin
      add_b = r.cmd.literal;
    end else begin
      add_b = src_file;
    end
    sum9       = {1'b0, r.acc} + {1'b0, add_b};
    sum_low    = {1'b0, r.acc[3:0]} + {1'b0, add_b[3:0]};
    tested_bit = src_file[r.cmd.bit_sel];
  end

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    next_r        = r;
    result        = sum9[BYTE_W-1:0];
    next_r.skip   = 1'b0;

    // Pin synchroniser and agreement filter.
    // Only the second stage reads the first, so a metastable level never reaches logic.
    next_r.pin_s1 = port_pins_in;
    next_r.pin_s2 = r.pin_s1;
    next_r.pin_s3 = r.pin_s2;
    if (r.pin_s2 == r.pin_s3) begin
      next_r.pins = r.pin_s3;
    end

    // Bus handshake: waitrequest drops for one cycle per request.
    next_r.waitreq = 1'b1;
    if (req && r.waitreq && r.state == ST_READY) begin
      next_r.waitreq = 1'b0;
      next_r.rdata   = UNMAPPED_READ;
      if (avs_read_in) begin
        if (file_hit) begin
          if (bus_idx == IO_PORT_INDEX) begin
            next_r.rdata = DATA_W'(r.pins);
          end else begin
            next_r.rdata = DATA_W'(r.files[bus_idx]);
          end
        end else begin
          case (avs_address_in)
            OFS_CMD: begin
              next_r.rdata = cmd_word;
            end
            OFS_ACC: begin
              next_r.rdata = DATA_W'(r.acc);
            end
            OFS_STATUS: begin
              next_r.rdata = status_word;
            end
            default: begin
              next_r.rdata = UNMAPPED_READ;
            end
          endcase
        end
      end
    end

    // Register writes take effect on the accepting edge.
    if (ack_edge && avs_write_in) begin
      if (file_hit) begin
        next_r.files[bus_idx] = file_merged[BYTE_W-1:0];
      end else begin
        case (avs_address_in)
          OFS_CMD: begin
            next_r.cmd.op        = abd_op_t'(cmd_merged[CMD_OP_LSB +: $bits(abd_op_t)]);
            next_r.cmd.dest_file = cmd_merged[CMD_DEST_BIT];
            next_r.cmd.bit_sel   = cmd_merged[CMD_BIT_LSB +: 3];
            next_r.cmd.file_addr = cmd_merged[CMD_ADDR_LSB +: FILE_AW];
            next_r.cmd.literal   = cmd_merged[CMD_LIT_LSB +: BYTE_W];
            next_r.state = ST_EXEC;
          end
          OFS_ACC: begin
            next_r.acc = acc_merged[BYTE_W-1:0];
          end
          OFS_STATUS: begin
            next_r.flags.carry           = st_merged[ST_CARRY];
            next_r.flags.half_carry_flag = st_merged[ST_HALF];
            next_r.flags.zero            = st_merged[ST_ZERO];
          end
          default: begin
          end
        endcase
      end
    end

    // Execution of one command.
    case (r.state)
      ST_READY: begin
      end
      ST_EXEC: begin
        next_r.state = ST_READY;
        // A pending skip swallows this command; its execute cycle is the idle cycle.
        if (r.skip_pending) begin
          next_r.skip_pending = 1'b0;
        end else begin
          case (r.cmd.op)
            OP_ADD_IMMEDIATE: begin
              next_r.acc                   = sum9[BYTE_W-1:0];
              next_r.flags.carry           = sum9[BYTE_W];
              next_r.flags.half_carry_flag = sum_low[4];
              next_r.flags.zero            = (sum9[BYTE_W-1:0] == 8'h00);
            end
            OP_ADD_ACC_WITH_FILE, OP_AND_ACC_WITH_FILE: begin
              if (r.cmd.op == OP_ADD_ACC_WITH_FILE) begin
                result                       = sum9[BYTE_W-1:0];
                next_r.flags.carry           = sum9[BYTE_W];
                next_r.flags.half_carry_flag = sum_low[4];
              end else begin
                result = r.acc & src_file;
              end
              next_r.flags.zero = (result == 8'h00);
              if (r.cmd.dest_file) begin
                next_r.files[r.cmd.file_addr] = result;
              end else begin
                next_r.acc = result;
              end
            end
            OP_AND_IMMEDIATE: begin
              next_r.acc        = r.acc & r.cmd.literal;
              next_r.flags.zero = ((r.acc & r.cmd.literal) == 8'h00);
            end
            OP_FILE_BIT_CLEAR: begin
              next_r.files[r.cmd.file_addr]                = src_file;
              next_r.files[r.cmd.file_addr][r.cmd.bit_sel] = 1'b0;
            end
            OP_FILE_BIT_SET: begin
              next_r.files[r.cmd.file_addr]                = src_file;
              next_r.files[r.cmd.file_addr][r.cmd.bit_sel] = 1'b1;
            end
            OP_SKIP_WHEN_BIT_LOW: begin
              next_r.skip_pending = ~tested_bit;
              next_r.skip         = ~tested_bit;
            end
            OP_SKIP_WHEN_BIT_HIGH: begin
              next_r.skip_pending = tested_bit;
              next_r.skip         = tested_bit;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_r.state = ST_READY;
      end
    endcase

    if (reset_in) begin
      next_r              = '0;
      next_r.state        = ST_READY;
      next_r.acc          = ACC_RESET;
      next_r.files        = {FILE_DEPTH{FILE_RESET}};
      next_r.waitreq      = 1'b1;
      next_r.rdata        = UNMAPPED_READ;
    end

    // Busy is a flop of its own so the output carries no decode logic.
    next_r.busy = (next_r.state == ST_EXEC);
  end

  // ----------------------------------------------------------------------
  // Registers and outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    r <= next_r;
  end

  always_comb begin
    avs_readdata_out    = r.rdata;
    avs_waitrequest_out = r.waitreq;
    port_latch_out      = r.files[IO_PORT_INDEX];
    skip_out            = r.skip;
    busy_out            = r.busy;
  end

endmodule
`default_nettype wire

// ### tb/abd_checker_assertions.sv
// Concurrent checks on the ports of the add and bit ops datapath.
`timescale 1ns/1ps
`default_nettype none
module abd_checker
  import abd_pkg::*;
(
  input wire logic              core_clk_in,
  input wire logic              reset_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic              avs_waitrequest_out,
  input wire logic [BYTE_W-1:0] port_latch_out,
  input wire logic              skip_out,
  input wire logic              busy_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence cmd_accept;
    avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CMD;
  endsequence
  sequence exec_once;
    busy_out ##1 !busy_out;
  endsequence
  a_cmd_exec: assert property (cmd_accept |=> exec_once)
    else $error("command did not execute for one cycle");
  a_ack_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_busy_holds_bus: assert property (busy_out |-> avs_waitrequest_out)
    else $error("request accepted during execution");
  a_answer_bound: assert property ($rose(avs_read_in || avs_write_in) |-> ##[1:3] !avs_waitrequest_out)
    else $error("request not answered in time");
  a_ack_needs_req: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
    else $error("acknowledge without request");
  a_skip_pulse: assert property (skip_out |=> !skip_out)
    else $error("skip pulse longer than one cycle");
  a_skip_cause: assert property (skip_out |-> $past(busy_out) && !busy_out)
    else $error("skip pulse without execution");
  a_latch_cause: assert property (!$stable(port_latch_out) |-> $past(busy_out) || $past(avs_write_in))
    else $error("port latch changed without cause");
endmodule
bind abd_datapath abd_checker u_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .port_latch_out(port_latch_out),
  .skip_out(skip_out), .busy_out(busy_out));
`default_nettype wire

// ### tb/abd_pin_model.sv
// External levels on the I/O port pins.
`timescale 1ns/1ps
`default_nettype none
module abd_pin_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] level_in,
  output var  logic [7:0] pins_out
);
  initial pins_out = 8'h00;
  // Pins follow the outside driver one clock later, never the latch.
  always @(posedge core_clk_in) begin
    pins_out <= level_in;
  end
endmodule
`default_nettype wire

// ### tb/abd_datapath_tb.sv
// Self-checking bench for the add and bit ops datapath.
`timescale 1ns/1ps
`default_nettype none
module abd_datapath_tb;
  import abd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd_r = 1'b0, wr_r = 1'b0, wt, skp, bsy;
  logic [ADDR_W-1:0] adr = 10'h000;
  logic [DATA_W-1:0] wd = 32'h0, rdata, q;
  logic [3:0]        be = 4'hF;
  logic [7:0]        lvl = 8'h00, pins, latch, s;
  logic [7:0]        av [4] = '{8'h0F, 8'hFF, 8'h80, 8'h12};
  logic [7:0]        kv [4] = '{8'h01, 8'h01, 8'h80, 8'h34};
  logic              sk;
  int                miscompares = 0, n_compared = 0, skips = 0;
  abd_pin_model pm (.core_clk_in(clk), .level_in(lvl), .pins_out(pins));
  abd_datapath dut (.core_clk_in(clk), .reset_in(rst), .avs_address_in(adr),
    .avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wt), .port_pins_in(pins),
    .port_latch_out(latch), .skip_out(skp), .busy_out(bsy));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (skp === 1'b1) skips++;
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    adr <= a;
    wr_r <= w;
    rd_r <= !w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input abd_op_t op, input logic d, input logic [2:0] b,
                     input logic [6:0] f, input logic [7:0] k);
    bus(OFS_CMD, 1'b1, {8'h00, k, 1'b0, f, b, d, op});
  endtask
  function automatic logic [9:0] fa(input int i);
    return {1'b1, 7'(i), 2'b00};
  endfunction
  function automatic logic [31:0] flg(input logic [7:0] a, b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return {29'h0, t[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, t[8]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(OFS_STATUS, 1'b0, 32'h0); chk("status reset", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(OFS_ACC, 1'b1, {24'h0, av[i]});
      bus(OFS_STATUS, 1'b1, 32'h0);
      cmd(OP_ADD_IMMEDIATE, 1'b0, 3'h0, 7'h00, kv[i]);
      s = av[i] + kv[i];
      bus(OFS_ACC, 1'b0, 32'h0); chk("add imm acc", q, {24'h0, s});
      bus(OFS_STATUS, 1'b0, 32'h0); chk("add imm flags", q, flg(av[i], kv[i]));
    end
    bus(fa(127), 1'b1, 32'h9C);
    bus(OFS_ACC, 1'b1, 32'h64);
    cmd(OP_ADD_ACC_WITH_FILE, 1'b0, 3'h0, 7'h7F, 8'h00);
    bus(OFS_ACC, 1'b0, 32'h0); chk("add file acc", q, 32'h0);
    bus(OFS_STATUS, 1'b0, 32'h0); chk("add file flags", q, 32'h7);
    bus(OFS_ACC, 1'b1, 32'h11);
    cmd(OP_ADD_ACC_WITH_FILE, 1'b1, 3'h0, 7'h7F, 8'h00);
    bus(fa(127), 1'b0, 32'h0); chk("add file dest", q, 32'hAD);
    bus(OFS_ACC, 1'b0, 32'h0); chk("acc kept", q, 32'h11);
    bus(OFS_STATUS, 1'b1, 32'h3);
    bus(OFS_ACC, 1'b1, 32'hF0);
    cmd(OP_AND_IMMEDIATE, 1'b0, 3'h0, 7'h00, 8'h0F);
    bus(OFS_STATUS, 1'b0, 32'h0); chk("and imm flags", q, 32'h7);
    bus(OFS_ACC, 1'b0, 32'h0); chk("and imm acc", q, 32'h0);
    bus(fa(20), 1'b1, 32'h3C);
    bus(OFS_ACC, 1'b1, 32'hF0);
    cmd(OP_AND_ACC_WITH_FILE, 1'b1, 3'h0, 7'h14, 8'h00);
    bus(fa(20), 1'b0, 32'h0); chk("and file dest", q, 32'h30);
    bus(OFS_STATUS, 1'b0, 32'h0); chk("and file flags", q, 32'h3);
    for (int b = 0; b < 8; b++) begin
      cmd(OP_FILE_BIT_SET, 1'b0, 3'(b), 7'h05, 8'h00);
      bus(fa(5), 1'b0, 32'h0); chk("bit set", q, 32'hFF >> (7 - b));
    end
    for (int b = 0; b < 8; b++) begin
      cmd(OP_FILE_BIT_CLEAR, 1'b0, 3'(b), 7'h05, 8'h00);
      bus(fa(5), 1'b0, 32'h0); chk("bit clear", q, (32'hFF << (b + 1)) & 32'hFF);
    end
    bus(OFS_STATUS, 1'b0, 32'h0); chk("bit ops flags", q, 32'h3);
    for (int j = 0; j < 4; j++) begin
      bus(fa(5), 1'b1, 32'(j % 2) << 2);
      bus(OFS_ACC, 1'b1, 32'h40);
      sk = (j < 2) ? (j % 2 == 0) : (j % 2 == 1);
      cmd((j < 2) ? OP_SKIP_WHEN_BIT_LOW : OP_SKIP_WHEN_BIT_HIGH, 1'b0, 3'h2, 7'h05, 8'h00);
      bus(OFS_STATUS, 1'b0, 32'h0); chk("skip pending", q[3], sk);
      cmd(OP_ADD_IMMEDIATE, 1'b0, 3'h0, 7'h00, 8'h01);
      bus(OFS_ACC, 1'b0, 32'h0); chk("after test", q, sk ? 32'h40 : 32'h41);
    end
    chk("skip pulses", skips, 32'd2);
    lvl <= 8'h0F;
    bus(fa(6), 1'b1, 32'hF0);
    repeat (6) @(posedge clk);
    cmd(OP_FILE_BIT_SET, 1'b0, 3'h7, 7'h06, 8'h00);
    @(posedge clk);
    chk("port latch", {24'h0, latch}, 32'h8F);
    bus(10'h00C, 1'b0, 32'h0);
    chk("unmapped read", q, UNMAPPED_READ);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
